// file: tmr_core.sv
// Purpose: 16-bit timer/event counter core with two compare/capture channels
// Assumes: APB slave, zero wait states, synchronous active-high reset
// Notes:   match requests are one-cycle pulses; no interrupt logic here
//
// Design decisions made here: the register offsets and the APB slave port.
`default_nettype none
module tmr_core #(
  parameter int unsigned PRE_W    = 7,
  parameter int unsigned FILT_LEN = 3
) (
  // clock and reset
  input  wire logic                         mclk_in,
  input  wire logic                         reset_in,
  // apb slave
  input  wire tmr_pkg::tmr_apb_req_t        apb_in,
  output logic [tmr_pkg::DATA_W-1:0]        prdata_out,
  output logic                              pready_out,
  output logic                              pslverr_out,
  // trigger pins
  input  wire logic                         trigger_in_zero_in,
  input  wire logic                         trigger_in_one_in,
  // timer outputs
  output logic                              timer_out_zero_out,
  output logic                              timer_out_one_out,
  // match requests
  output logic                              match_irq_zero_out,
  output logic                              match_irq_one_out
);
  localparam int unsigned CW = tmr_pkg::CNT_W;

  function automatic logic edge_hit(input logic [1:0] sel, input tmr_pkg::tmr_edges_t e);
    edge_hit = 1'b0;
    unique case (tmr_pkg::tmr_edge_t'(sel))
      tmr_pkg::TMR_EDGE_NONE: edge_hit = 1'b0;
      tmr_pkg::TMR_EDGE_RISE: edge_hit = e.rise;
      tmr_pkg::TMR_EDGE_FALL: edge_hit = e.fall;
      tmr_pkg::TMR_EDGE_BOTH: edge_hit = e.rise | e.fall;
    endcase
  endfunction

  function automatic logic [7:0] wr8(input logic [7:0] old, input logic [7:0] msk,
                                     input tmr_pkg::tmr_apb_req_t r);
    wr8 = r.pstrb[0] ? (r.pwdata[7:0] & msk) : old;
  endfunction

  function automatic logic [CW-1:0] wr16(input logic [CW-1:0] old,
                                         input tmr_pkg::tmr_apb_req_t r);
    wr16 = {r.pstrb[1] ? r.pwdata[15:8] : old[15:8],
            r.pstrb[0] ? r.pwdata[7:0]  : old[7:0]};
  endfunction

  // control registers
  logic [7:0] ctl0_r, ctl0_nxt;
  logic [7:0] ctl1_r, ctl1_nxt;
  logic [7:0] outc_r, outc_nxt;
  logic [7:0] edga_r, edga_nxt;
  logic [7:0] edgb_r, edgb_nxt;
  logic [7:0] nfca_r, nfca_nxt;
  logic [7:0] nfcb_r, nfcb_nxt;
  logic [7:0] opt_r,  opt_nxt;
  // channel, buffer and count state
  logic [CW-1:0]    ccr0_r, ccr0_nxt;
  logic [CW-1:0]    ccr1_r, ccr1_nxt;
  logic [CW-1:0]    buf0_r, buf0_nxt;
  logic [CW-1:0]    buf1_r, buf1_nxt;
  logic [CW-1:0]    cnt_r,  cnt_nxt;
  logic [PRE_W-1:0] pre_r,  pre_nxt;
  logic [1:0]       tog_r,  tog_nxt;
  logic [1:0]       out_r,  out_nxt;
  logic [1:0]       irq_r,  irq_nxt;
  // bus answer
  logic [31:0] prdata_r, prdata_nxt;
  logic        perr_r,   perr_nxt;

  logic                run;
  logic [tmr_pkg::CKS_W-1:0] cks;
  logic [PRE_W-1:0]    pmask;
  logic                tick_int, tick_ev, tick;
  logic                cap0, cap1, match0, match1;
  logic                wr, setup;
  logic [CW-1:0]       cnt_inc;
  tmr_pkg::tmr_edges_t e0, e1;

  assign run = ctl0_r[tmr_pkg::CTL0_RUN_BIT];
  assign cks = ctl0_r[tmr_pkg::CTL0_CKS_LSB +: tmr_pkg::CKS_W];

  // trigger zero filters only as capture input; its edges also feed event count
  tmr_trig #(.FILT_LEN(FILT_LEN)) u_trig0 (
    .mclk_in    (mclk_in),
    .reset_in   (reset_in),
    .pin_in     (trigger_in_zero_in),
    .filt_en_in (nfca_r[tmr_pkg::NFC_EN_BIT] & opt_r[tmr_pkg::OPT_CAP0_BIT]),
    .edges_out  (e0)
  );

  tmr_trig #(.FILT_LEN(FILT_LEN)) u_trig1 (
    .mclk_in    (mclk_in),
    .reset_in   (reset_in),
    .pin_in     (trigger_in_one_in),
    .filt_en_in (nfcb_r[tmr_pkg::NFC_EN_BIT] & opt_r[tmr_pkg::OPT_CAP1_BIT]),
    .edges_out  (e1)
  );

  // count clock selection
  // the prescaler restarts from zero on every start, so the first tick is predictable
  always_comb begin
    pmask    = PRE_W'((1 << cks) - 1);
    tick_int = run & ((pre_r & pmask) == pmask);
    tick_ev  = run & edge_hit(edgb_r[tmr_pkg::EDGB_EVT_LSB +: tmr_pkg::EDG_W], e0);
    tick     = ctl1_r[tmr_pkg::CTL1_EVT_BIT] ? tick_ev : tick_int;
    pre_nxt  = run ? pre_r + 1'b1 : '0;
    cnt_inc  = cnt_r + 1'b1;
  end

  // counter, compare, capture and outputs
  always_comb begin
    cap0 = run & opt_r[tmr_pkg::OPT_CAP0_BIT]
         & edge_hit(edga_r[tmr_pkg::EDGA_CH0_LSB +: tmr_pkg::EDG_W], e0);
    cap1 = run & opt_r[tmr_pkg::OPT_CAP1_BIT]
         & edge_hit(edga_r[tmr_pkg::EDGA_CH1_LSB +: tmr_pkg::EDG_W], e1);
    match0 = tick & ~opt_r[tmr_pkg::OPT_CAP0_BIT] & (cnt_inc == buf0_r);
    match1 = tick & ~opt_r[tmr_pkg::OPT_CAP1_BIT] & (cnt_inc == buf1_r);
    if (!run) begin
      cnt_nxt = tmr_pkg::CNT_HELD;
    end else if (tick) begin
      cnt_nxt = cnt_inc;
    end else begin
      cnt_nxt = cnt_r;
    end
    irq_nxt = {match1, match0};
    tog_nxt = run ? (tog_r ^ {match1, match0}) : 2'b00;
    out_nxt[0] = outc_r[tmr_pkg::OUTC_EN0_BIT]
               & (outc_r[tmr_pkg::OUTC_LV0_BIT] ^ tog_nxt[0]);
    out_nxt[1] = outc_r[tmr_pkg::OUTC_EN1_BIT]
               & (outc_r[tmr_pkg::OUTC_LV1_BIT] ^ tog_nxt[1]);
  end

  // register writes
  always_comb begin
    wr       = apb_in.psel & apb_in.penable & apb_in.pwrite;
    ctl0_nxt = ctl0_r;
    ctl1_nxt = ctl1_r;
    outc_nxt = outc_r;
    edga_nxt = edga_r;
    edgb_nxt = edgb_r;
    nfca_nxt = nfca_r;
    nfcb_nxt = nfcb_r;
    opt_nxt  = opt_r;
    ccr0_nxt = ccr0_r;
    ccr1_nxt = ccr1_r;
    buf0_nxt = buf0_r;
    buf1_nxt = buf1_r;
    if (wr) begin
      unique case (apb_in.paddr)
        tmr_pkg::OFS_CTL0: ctl0_nxt = wr8(ctl0_r, tmr_pkg::CTL0_MASK, apb_in);
        tmr_pkg::OFS_CTL1: ctl1_nxt = wr8(ctl1_r, tmr_pkg::CTL1_MASK, apb_in);
        tmr_pkg::OFS_OUTC: outc_nxt = wr8(outc_r, tmr_pkg::OUTC_MASK, apb_in);
        tmr_pkg::OFS_EDGA: edga_nxt = wr8(edga_r, tmr_pkg::EDGA_MASK, apb_in);
        tmr_pkg::OFS_EDGB: edgb_nxt = wr8(edgb_r, tmr_pkg::EDGB_MASK, apb_in);
        tmr_pkg::OFS_NFCA: nfca_nxt = wr8(nfca_r, tmr_pkg::NFC_MASK, apb_in);
        tmr_pkg::OFS_NFCB: nfcb_nxt = wr8(nfcb_r, tmr_pkg::NFC_MASK, apb_in);
        tmr_pkg::OFS_OPT:  opt_nxt  = wr8(opt_r, tmr_pkg::OPT_MASK, apb_in);
        tmr_pkg::OFS_CCR0: begin
          ccr0_nxt = wr16(ccr0_r, apb_in);
          if (!opt_r[tmr_pkg::OPT_CAP0_BIT]) begin
            buf0_nxt = wr16(ccr0_r, apb_in);
          end
        end
        tmr_pkg::OFS_CCR1: begin
          ccr1_nxt = wr16(ccr1_r, apb_in);
          if (!opt_r[tmr_pkg::OPT_CAP1_BIT]) begin
            buf1_nxt = wr16(ccr1_r, apb_in);
          end
        end
        default: ;
      endcase
    end
    // a capture edge wins over a software write in the same cycle
    if (cap0) begin
      ccr0_nxt = cnt_r;
    end
    if (cap1) begin
      ccr1_nxt = cnt_r;
    end
  end

  // read data and error are latched in the setup cycle, answered in access
  // a counter read while stopped answers zero, not the held all ones
  always_comb begin
    setup      = apb_in.psel & ~apb_in.penable;
    prdata_nxt = prdata_r;
    perr_nxt   = perr_r;
    if (setup) begin
      perr_nxt   = 1'b0;
      prdata_nxt = tmr_pkg::RD_ZERO;
      unique case (apb_in.paddr)
        tmr_pkg::OFS_CTL0: prdata_nxt[7:0] = ctl0_r;
        tmr_pkg::OFS_CTL1: prdata_nxt[7:0] = ctl1_r;
        tmr_pkg::OFS_OUTC: prdata_nxt[7:0] = outc_r;
        tmr_pkg::OFS_EDGA: prdata_nxt[7:0] = edga_r;
        tmr_pkg::OFS_EDGB: prdata_nxt[7:0] = edgb_r;
        tmr_pkg::OFS_NFCA: prdata_nxt[7:0] = nfca_r;
        tmr_pkg::OFS_NFCB: prdata_nxt[7:0] = nfcb_r;
        tmr_pkg::OFS_OPT:  prdata_nxt[7:0] = opt_r;
        tmr_pkg::OFS_CCR0: prdata_nxt[CW-1:0] = ccr0_r;
        tmr_pkg::OFS_CCR1: prdata_nxt[CW-1:0] = ccr1_r;
        tmr_pkg::OFS_CNT:  prdata_nxt[CW-1:0] = run ? cnt_r : tmr_pkg::CNT_RD_OFF;
        default:           perr_nxt = 1'b1;
      endcase
    end
  end

  // prescaler
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      pre_r <= '0;
    end else begin
      pre_r <= pre_nxt;
    end
  end

  // counter, toggle, output and match state
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      cnt_r <= tmr_pkg::CNT_HELD;
      tog_r <= 2'b00;
      out_r <= 2'b00;
      irq_r <= 2'b00;
    end else begin
      cnt_r <= cnt_nxt;
      tog_r <= tog_nxt;
      out_r <= out_nxt;
      irq_r <= irq_nxt;
    end
  end

  // software-visible registers and hidden compare buffers
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      ctl0_r <= tmr_pkg::REG8_RST;
      ctl1_r <= tmr_pkg::REG8_RST;
      outc_r <= tmr_pkg::REG8_RST;
      edga_r <= tmr_pkg::REG8_RST;
      edgb_r <= tmr_pkg::REG8_RST;
      nfca_r <= tmr_pkg::REG8_RST;
      nfcb_r <= tmr_pkg::REG8_RST;
      opt_r  <= tmr_pkg::REG8_RST;
      ccr0_r <= tmr_pkg::CCR_RST;
      ccr1_r <= tmr_pkg::CCR_RST;
      buf0_r <= tmr_pkg::CCR_RST;
      buf1_r <= tmr_pkg::CCR_RST;
    end else begin
      ctl0_r <= ctl0_nxt;
      ctl1_r <= ctl1_nxt;
      outc_r <= outc_nxt;
      edga_r <= edga_nxt;
      edgb_r <= edgb_nxt;
      nfca_r <= nfca_nxt;
      nfcb_r <= nfcb_nxt;
      opt_r  <= opt_nxt;
      ccr0_r <= ccr0_nxt;
      ccr1_r <= ccr1_nxt;
      buf0_r <= buf0_nxt;
      buf1_r <= buf1_nxt;
    end
  end

  // bus answer
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      prdata_r <= tmr_pkg::RD_ZERO;
      perr_r   <= 1'b0;
    end else begin
      prdata_r <= prdata_nxt;
      perr_r   <= perr_nxt;
    end
  end

  assign pready_out         = 1'b1;
  assign prdata_out         = prdata_r;
  assign pslverr_out        = perr_r & apb_in.psel & apb_in.penable;
  assign timer_out_zero_out = out_r[0];
  assign timer_out_one_out  = out_r[1];
  assign match_irq_zero_out = irq_r[0];
  assign match_irq_one_out  = irq_r[1];
endmodule
`default_nettype wire

// file: tmr_pkg.sv
// Purpose: shared constants and carrier types of the 16-bit timer/event counter core
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes:   offsets are byte addresses
`default_nettype none
package tmr_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CNT_W  = 16;

  // register byte addresses
  localparam logic [ADDR_W-1:0] OFS_CTL0 = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CTL1 = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_OUTC = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_EDGA = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_EDGB = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_NFCA = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_NFCB = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_CCR0 = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_CCR1 = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_CNT  = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_OPT  = 8'h28;

  // field positions
  localparam int unsigned CTL0_RUN_BIT = 7;
  localparam int unsigned CTL0_CKS_LSB = 0;
  localparam int unsigned CKS_W        = 3;
  localparam int unsigned CTL1_EVT_BIT = 5;
  localparam int unsigned OUTC_EN0_BIT = 0;
  localparam int unsigned OUTC_LV0_BIT = 1;
  localparam int unsigned OUTC_EN1_BIT = 2;
  localparam int unsigned OUTC_LV1_BIT = 3;
  localparam int unsigned EDG_W        = 2;
  localparam int unsigned EDGA_CH0_LSB = 0;
  localparam int unsigned EDGA_CH1_LSB = 2;
  localparam int unsigned EDGB_EVT_LSB = 0;
  localparam int unsigned NFC_EN_BIT   = 0;
  localparam int unsigned OPT_CAP0_BIT = 0;
  localparam int unsigned OPT_CAP1_BIT = 1;

  // writable masks and reset values
  localparam logic [7:0]  CTL0_MASK  = 8'h87;
  localparam logic [7:0]  CTL1_MASK  = 8'h20;
  localparam logic [7:0]  OUTC_MASK  = 8'h0f;
  localparam logic [7:0]  EDGA_MASK  = 8'h0f;
  localparam logic [7:0]  EDGB_MASK  = 8'h03;
  localparam logic [7:0]  NFC_MASK   = 8'h01;
  localparam logic [7:0]  OPT_MASK   = 8'h03;
  localparam logic [7:0]  REG8_RST   = 8'h00;
  localparam logic [15:0] CCR_RST    = 16'h0000;
  localparam logic [15:0] CNT_HELD   = 16'hffff;
  localparam logic [15:0] CNT_RD_OFF = 16'h0000;
  localparam logic [31:0] RD_ZERO    = 32'h0000_0000;

  typedef enum logic [1:0] {
    TMR_EDGE_NONE = 2'h0,
    TMR_EDGE_RISE = 2'h1,
    TMR_EDGE_FALL = 2'h2,
    TMR_EDGE_BOTH = 2'h3
  } tmr_edge_t;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
    logic [3:0]        pstrb;
  } tmr_apb_req_t;

  typedef struct packed {
    logic rise;
    logic fall;
  } tmr_edges_t;
endpackage
`default_nettype wire

// file: tmr_trig.sv
// Purpose: trigger pin conditioner: synchroniser, optional noise filter, edge pulses
// Assumes: pin is asynchronous to mclk_in
// Notes:   filter demands FILT_LEN agreeing samples before the level moves
`default_nettype none
module tmr_trig #(
  parameter int unsigned FILT_LEN = 3
) (
  // clock and reset
  input  wire logic                mclk_in,
  input  wire logic                reset_in,
  // pin and control
  input  wire logic                pin_in,
  input  wire logic                filt_en_in,
  // detected edges
  output tmr_pkg::tmr_edges_t      edges_out
);
  localparam int unsigned FC_W = $clog2(FILT_LEN + 1);
  localparam logic [FC_W-1:0] FC_LAST = FC_W'(FILT_LEN - 1);

  logic            s1_r, s2_r, s3_r;
  logic            lvl_r, lvl_nxt;
  logic [FC_W-1:0] fc_r, fc_nxt;
  tmr_pkg::tmr_edges_t edg_nxt, edg_r;

  always_comb begin
    lvl_nxt = lvl_r;
    fc_nxt  = '0;
    if (s2_r == s3_r && s3_r != lvl_r) begin
      if (!filt_en_in || fc_r == FC_LAST) begin
        lvl_nxt = s3_r;
      end else begin
        fc_nxt = fc_r + 1'b1;
      end
    end
    edg_nxt.rise = lvl_nxt & ~lvl_r;
    edg_nxt.fall = ~lvl_nxt & lvl_r;
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      s1_r  <= 1'b0;
      s2_r  <= 1'b0;
      s3_r  <= 1'b0;
      lvl_r <= 1'b0;
      fc_r  <= '0;
      edg_r <= '0;
    end else begin
      s1_r  <= pin_in;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      lvl_r <= lvl_nxt;
      fc_r  <= fc_nxt;
      edg_r <= edg_nxt;
    end
  end

  assign edges_out = edg_r;
endmodule
`default_nettype wire

// file: tmr_pins.sv
// Purpose: far-side model that drives both trigger pins
// Assumes: pins rest low between bursts
// Notes:   each pulse is 6 cycles low then 6 cycles high; the task returns as the pin goes low
`default_nettype none
module tmr_pins (
  // clock
  input  wire logic mclk_in,
  // trigger pins
  output logic      trig_zero_out,
  output logic      trig_one_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial trig_zero_out = 1'b0;
  initial trig_one_out = 1'b0;
  task automatic pulses(input int n);
    repeat (n) begin
      repeat (6) @(posedge mclk_in);
      trig_zero_out <= 1'b1;
      trig_one_out  <= 1'b1;
      repeat (6) @(posedge mclk_in);
      trig_zero_out <= 1'b0;
      trig_one_out  <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// file: tmr_core_chk.sv
// Purpose: port checker for the timer core
// Assumes: one clock, sees only the top ports
// Notes:   shadows run bit and output control from bus writes
`default_nettype none
module tmr_core_chk (
  // clock and reset
  input wire logic                  mclk_in,
  input wire logic                  reset_in,
  // apb
  input wire tmr_pkg::tmr_apb_req_t apb_in,
  input wire logic [31:0]           prdata_out,
  input wire logic                  pready_out,
  input wire logic                  pslverr_out,
  // pins
  input wire logic                  trigger_in_zero_in,
  input wire logic                  trigger_in_one_in,
  input wire logic                  timer_out_zero_out,
  input wire logic                  timer_out_one_out,
  input wire logic                  match_irq_zero_out,
  input wire logic                  match_irq_one_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  logic       acc;
  logic       wr_ok;
  logic       run;
  logic       rst_r;
  logic [7:0] ctl_r, ctl_nxt;
  logic [7:0] outc_r, outc_nxt;
  logic [1:0] calm_r, calm_nxt;
  assign acc   = apb_in.psel && apb_in.penable;
  assign wr_ok = acc && apb_in.pwrite && apb_in.pstrb[0];
  assign run   = ctl_r[tmr_pkg::CTL0_RUN_BIT];
  // calm counts cycles since the last bus write
  always_comb begin
    ctl_nxt  = ctl_r;
    outc_nxt = outc_r;
    calm_nxt = (calm_r == 2'h3) ? calm_r : calm_r + 2'h1;
    if (wr_ok) begin
      calm_nxt = 2'h0;
      if (apb_in.paddr == tmr_pkg::OFS_CTL0) begin
        ctl_nxt = apb_in.pwdata[7:0] & tmr_pkg::CTL0_MASK;
      end
      if (apb_in.paddr == tmr_pkg::OFS_OUTC) begin
        outc_nxt = apb_in.pwdata[7:0] & tmr_pkg::OUTC_MASK;
      end
    end
  end
  always_ff @(posedge mclk_in) begin
    rst_r <= reset_in;
    if (reset_in) begin
      ctl_r  <= 8'h00;
      outc_r <= 8'h00;
      calm_r <= 2'h3;
    end else begin
      ctl_r  <= ctl_nxt;
      outc_r <= outc_nxt;
      calm_r <= calm_nxt;
    end
  end
  sequence apb_rd(a);
    apb_in.psel && !apb_in.penable && !apb_in.pwrite && apb_in.paddr == a ##1 acc;
  endsequence
  AST_RST_QUIET: assert property (
    rst_r |-> !timer_out_zero_out && !timer_out_one_out && !match_irq_zero_out
      && !match_irq_one_out && prdata_out == 32'h0)
    else $error("outputs not idle after reset");
  AST_IRQ0_PULSE: assert property (
    match_irq_zero_out |=> !match_irq_zero_out)
    else $error("match zero longer than one cycle");
  AST_IRQ1_PULSE: assert property (
    match_irq_one_out |=> !match_irq_one_out)
    else $error("match one longer than one cycle");
  AST_STOP_NO_MATCH: assert property (
    !run && calm_r != 2'h0 |-> !match_irq_zero_out && !match_irq_one_out)
    else $error("match while stopped");
  AST_STOP_OUTS: assert property (
    !run && calm_r == 2'h3 |-> timer_out_zero_out == (outc_r[0] & outc_r[1])
      && timer_out_one_out == (outc_r[2] & outc_r[3]))
    else $error("outputs not at idle level while stopped");
  AST_CNT_STOPPED: assert property (
    apb_rd(tmr_pkg::OFS_CNT) ##0 !run |-> prdata_out == 32'h0)
    else $error("counter read not zero while stopped");
  AST_CTL0_READ: assert property (
    apb_rd(tmr_pkg::OFS_CTL0) |-> prdata_out == {24'h0, ctl_r})
    else $error("control zero readback wrong");
  AST_BUS_ERR: assert property (
    acc |-> pready_out && pslverr_out == (apb_in.paddr > tmr_pkg::OFS_OPT))
    else $error("bus error flag wrong");
endmodule
`default_nettype wire

// file: tb_top.sv
// Purpose: self-checking bench for the timer core
// Assumes: zero-wait apb slave, trigger pins from the pin model
// Notes:   checker bound at the foot of this file
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic                  mclk_in = 1'b0;
  logic                  reset_in = 1'b1;
  tmr_pkg::tmr_apb_req_t req = '0;
  logic [31:0]           prdata;
  logic                  pready, pslverr, out0, out1, irq0, irq1;
  wire logic             trig0, trig1;
  logic [31:0]           q;
  logic                  e;
  int                    n;
  int                    miscompares = 0;
  int                    total_checks = 0;
  always #50 mclk_in = ~mclk_in;
  tmr_pins pins (.mclk_in(mclk_in), .trig_zero_out(trig0), .trig_one_out(trig1));
  tmr_core uut (
    .mclk_in(mclk_in), .reset_in(reset_in), .apb_in(req), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .trigger_in_zero_in(trig0),
    .trigger_in_one_in(trig1), .timer_out_zero_out(out0), .timer_out_one_out(out1),
    .match_irq_zero_out(irq0), .match_irq_one_out(irq1)
  );
  task automatic chk_v(input logic [31:0] g, input logic [31:0] x, input string m);
    total_checks++;
    if (g !== x) begin
      miscompares++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, g, x);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    req.psel    <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite  <= w;
    req.paddr   <= a;
    req.pwdata  <= d;
    req.pstrb   <= 4'hf;
    @(posedge mclk_in);
    req.penable <= 1'b1;
    @(posedge mclk_in);
    while (pready !== 1'b1) @(posedge mclk_in);
    q = prdata;
    e = pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask
  // n = cycles from the write's access edge to the match pulse
  task automatic wait_irq(input logic ch);
    n = 0;
    do begin
      @(posedge mclk_in);
      #1;
      n++;
    end while ((ch ? irq1 : irq0) !== 1'b1 && n < 400);
  endtask
  task automatic t_reset();
    apb(0, tmr_pkg::OFS_CTL0, 0); chk_v(q, 32'h0, "ctl0 reset");
    apb(0, tmr_pkg::OFS_CNT, 0); chk_v(q, 32'h0, "count stopped");
    apb(0, tmr_pkg::OFS_CCR0, 0); chk_v(q, 32'h0, "ccr0 reset");
    apb(0, tmr_pkg::OFS_CCR1, 0); chk_v(q, 32'h0, "ccr1 reset");
    apb(1, 8'h40, 32'h1); chk_v({31'h0, e}, 32'h1, "unmapped error");
    $display("test reset done");
  endtask
  task automatic t_ctl0();
    apb(1, tmr_pkg::OFS_CTL0, 32'hff);
    apb(0, tmr_pkg::OFS_CTL0, 0); chk_v(q, 32'h87, "ctl0 mask");
    apb(1, tmr_pkg::OFS_CTL0, 32'h87);
    apb(0, tmr_pkg::OFS_CTL0, 0); chk_v(q, 32'h87, "ctl0 rewrite");
    apb(0, tmr_pkg::OFS_CNT, 0); chk_v(q, 32'hffff, "count before tick");
    apb(1, tmr_pkg::OFS_CTL0, 0);
    apb(0, tmr_pkg::OFS_CNT, 0); chk_v(q, 32'h0, "count stopped");
    $display("test ctl0 done");
  endtask
  task automatic t_cmp();
    apb(1, tmr_pkg::OFS_CCR0, 32'h3);
    apb(1, tmr_pkg::OFS_CCR1, 32'h5);
    apb(1, tmr_pkg::OFS_OUTC, 32'h5);
    apb(1, tmr_pkg::OFS_CTL0, 32'h80);
    wait_irq(0); chk_v(n, 4, "match zero delay");
    wait_irq(1); chk_v(n, 2, "match one delay");
    repeat (2) @(posedge mclk_in);
    #1;
    chk_v({out1, out0}, 32'h3, "outputs toggled");
    apb(1, tmr_pkg::OFS_CTL0, 0);
    repeat (3) @(posedge mclk_in);
    #1;
    chk_v({out1, out0}, 32'h0, "outputs idle");
    $display("test compare done");
  endtask
  task automatic t_presc();
    apb(1, tmr_pkg::OFS_CCR0, 32'h1);
    for (int k = 0; k < 8; k++) begin
      apb(1, tmr_pkg::OFS_CTL0, 32'h80 | k);
      wait_irq(0); chk_v(n, 2 << k, "divided tick");
      apb(1, tmr_pkg::OFS_CTL0, 0);
    end
    $display("test prescale done");
  endtask
  task automatic t_evt();
    int t;
    apb(1, tmr_pkg::OFS_CTL1, 32'h20);
    for (int m = 0; m < 4; m++) begin
      t = (m == 3) ? 4 : ((m == 0) ? 0 : 2);
      apb(1, tmr_pkg::OFS_EDGB, m);
      apb(1, tmr_pkg::OFS_CTL0, 32'h80);
      pins.pulses(2);
      // the last falling edge takes four cycles through the pin conditioner
      repeat (6) @(posedge mclk_in);
      apb(0, tmr_pkg::OFS_CNT, 0);
      chk_v(q, {16'h0, 16'hffff + 16'(t)}, "event count");
      apb(1, tmr_pkg::OFS_CTL0, 0);
    end
    $display("test event done");
  endtask
  // ch0 captures filtered rising edges, ch1 unfiltered falling edges
  task automatic t_cap();
    apb(1, tmr_pkg::OFS_CTL1, 32'h0);
    apb(1, tmr_pkg::OFS_OPT, 32'h3);
    apb(1, tmr_pkg::OFS_EDGA, 32'h9);
    apb(1, tmr_pkg::OFS_NFCA, 32'h1);
    apb(1, tmr_pkg::OFS_CTL0, 32'h80);
    pins.pulses(1);
    repeat (8) @(posedge mclk_in);
    apb(0, tmr_pkg::OFS_CCR0, 0); chk_v(q, 32'hb, "filtered rise capture");
    apb(0, tmr_pkg::OFS_CCR1, 0); chk_v(q, 32'hf, "fall capture");
    apb(1, tmr_pkg::OFS_CTL0, 0);
    reset_in <= 1'b1;
    repeat (2) @(posedge mclk_in);
    reset_in <= 1'b0;
    apb(0, tmr_pkg::OFS_CCR0, 0); chk_v(q, 32'h0, "ccr0 after reset");
    apb(0, tmr_pkg::OFS_CCR1, 0); chk_v(q, 32'h0, "ccr1 after reset");
    $display("test capture done");
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge mclk_in);
    reset_in <= 1'b0;
    t_reset();
    t_ctl0();
    t_cmp();
    t_presc();
    t_evt();
    t_cap();
    close_out();
  end
  initial begin
    repeat (20000) @(posedge mclk_in);
    miscompares++;
    close_out();
  end
endmodule
bind tmr_core tmr_core_chk chk (
  .mclk_in(mclk_in), .reset_in(reset_in), .apb_in(apb_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out),
  .trigger_in_zero_in(trigger_in_zero_in), .trigger_in_one_in(trigger_in_one_in),
  .timer_out_zero_out(timer_out_zero_out), .timer_out_one_out(timer_out_one_out),
  .match_irq_zero_out(match_irq_zero_out), .match_irq_one_out(match_irq_one_out)
);
`default_nettype wire
